/* design/fsp_pkg.sv */
// Purpose: Shared constants and types of the flash sector write-protection block.
// Assumes: 100 MHz clock; 32-bit Avalon-MM register port.
// Notes: Offsets are byte addresses of aligned 32-bit registers.
package fsp_pkg;
	localparam int FSP_NUM_SECT = 8;
	localparam logic [2:0] FSP_TOP_SECT = 3'h6;
	localparam logic [2:0] FSP_BANK0_LAST = 3'h1;
	localparam logic [4:0] FSP_OFS_CTRL = 5'h00;
	localparam logic [4:0] FSP_OFS_CMD = 5'h04;
	localparam logic [4:0] FSP_OFS_DATA = 5'h08;
	localparam logic [4:0] FSP_OFS_STAT = 5'h0c;
	localparam int FSP_CTRL_ENTRY = 0;
	localparam int FSP_CTRL_FUSE = 1;
	localparam int FSP_CTRL_CFG_LSB = 8;
	localparam int FSP_CMD_WSEL_LSB = 4;
	localparam int FSP_CMD_SECT_LSB = 8;
	localparam int FSP_CMD_SECSI = 11;
	localparam int FSP_CLK_NS = 10;
	localparam int FSP_UNLOCK_GAP_NS = 1000;
	localparam int FSP_UNLOCK_TIME_NS = 1000;
	localparam int FSP_MIN_RESET_PULSE_NS = 30;
	localparam int FSP_TIMEOUT_NS = 1000;
	localparam int FSP_POLL_NS = 200;
	localparam logic [7:0] FSP_UNLOCK_GAP_CYC =
		8'((FSP_UNLOCK_GAP_NS + FSP_CLK_NS - 1) / FSP_CLK_NS);
	localparam logic [7:0] FSP_UNLOCK_TIME_CYC = 8'(FSP_UNLOCK_TIME_NS / FSP_CLK_NS);
	localparam logic [3:0] FSP_RESET_PULSE_CYC =
		4'((FSP_MIN_RESET_PULSE_NS + FSP_CLK_NS - 1) / FSP_CLK_NS);
	localparam logic [7:0] FSP_TIMEOUT_CYC = 8'(FSP_TIMEOUT_NS / FSP_CLK_NS);
	localparam logic [7:0] FSP_POLL_CYC = 8'(FSP_POLL_NS / FSP_CLK_NS);
	localparam logic [2:0] FSP_BOOT_SETTLE = 3'h5;
	localparam logic [5:0] FSP_PIN_IDLE = 6'h3f;

	typedef enum logic [3:0] {
		FSP_OP_NONE = 4'h0,
		FSP_OP_SEC_PROG = 4'h1,
		FSP_OP_SEC_READ = 4'h2,
		FSP_OP_UNLOCK = 4'h3,
		FSP_OP_FREEZE_SET = 4'h4,
		FSP_OP_PLOCK_PROG = 4'h5,
		FSP_OP_PLOCK_ERASE = 4'h6,
		FSP_OP_VLOCK_SET = 4'h7,
		FSP_OP_VLOCK_CLR = 4'h8,
		FSP_OP_ARR_PROG = 4'h9,
		FSP_OP_ARR_ERASE = 4'ha,
		FSP_OP_VLOCK_STAT = 4'hb,
		FSP_OP_PLOCK_STAT = 4'hc,
		FSP_OP_FREEZE_STAT = 4'hd
	} fsp_op_t;

	typedef enum logic [2:0] {
		FSP_RES_NONE = 3'h0,
		FSP_RES_OK = 3'h1,
		FSP_RES_REFUSED = 3'h2,
		FSP_RES_TIMEOUT = 3'h3,
		FSP_RES_PROTECTED = 3'h4,
		FSP_RES_MISMATCH = 3'h5
	} fsp_res_t;

	typedef enum logic [1:0] {
		FSP_ST_IDLE = 2'b01,
		FSP_ST_WAIT = 2'b10
	} fsp_st_t;

	typedef struct packed {
		fsp_st_t st;
		logic [5:0] sy1;
		logic [5:0] sy2;
		logic [5:0] sy3;
		logic [5:0] pin_f;
		logic we_prev;
		logic [2:0] boot_cnt;
		logic inhibit;
		logic [3:0] rp_cnt;
		logic out_en;
		logic wreq;
		logic [31:0] rdata;
		logic entry;
		logic fuse;
		logic [7:0] cfg;
		logic [11:0] cmd_last;
		logic [15:0] data;
		fsp_res_t result;
		logic freeze;
		logic [3:0][15:0] secret;
		logic [3:0][15:0] stage;
		logic [3:0] stage_mask;
		logic verify;
		logic [7:0] gap;
		logic [7:0] cnt;
		logic pend_clear;
		fsp_res_t pend_result;
		logic [7:0] plock;
		logic [7:0] vlock;
		logic go;
		logic go_erase;
		logic [2:0] go_sect;
	} fsp_state_t;

	localparam fsp_state_t FSP_RESET_Q = '{
		st: FSP_ST_IDLE, sy1: FSP_PIN_IDLE, sy2: FSP_PIN_IDLE, sy3: FSP_PIN_IDLE,
		pin_f: FSP_PIN_IDLE, we_prev: 1'b1, out_en: 1'b1, wreq: 1'b1, freeze: 1'b1,
		secret: '1, plock: '1, result: FSP_RES_NONE, pend_result: FSP_RES_NONE,
		default: '0};
endpackage

/* design/fsp_protect.sv */
// Purpose: Sector write protection: secret-guarded freeze release, lock decode, pin overrides.
// Assumes: rst_n_i models power up; hw_reset_n_i is the device reset pin.
// Notes: The array itself is outside; array_go_o grants a program or erase.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsp_protect
	import fsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic write_protect_n_i,
	input wire logic program_supply_pin_i,
	input wire logic hw_reset_n_i,
	input wire logic we_n_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	output logic out_en_o,
	output logic bank0_block_o,
	output logic array_go_o,
	output logic array_erase_o,
	output logic [2:0] array_sector_o
);
	fsp_state_t q;
	fsp_state_t d;
	logic [7:0] prot_w;
	logic [31:0] wmask;
	logic bus_go;
	logic wr_go;
	logic hw_fire;
	logic attempt;
	logic match_fire;
	logic cmd_wr;
	logic rd_ok;

	genvar gi;
	generate
		for (gi = 0; gi < FSP_NUM_SECT; gi++)
		begin : g_prot
			assign prot_w[gi] = ~q.plock[gi] | ~q.vlock[gi] | ~q.pin_f[1]
				| ((3'(gi) >= FSP_TOP_SECT) & ~q.pin_f[0]);
		end
	endgenerate

	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign bus_go = (avs_read_i | avs_write_i) & q.wreq;
	// A write lands only at the edge that sees waitrequest low, never while it stalls.
	// Reads are captured one edge earlier so that the data stand when the master takes them.
	assign wr_go = avs_write_i & ~q.wreq;
	assign cmd_wr = wr_go & (avs_address_i == FSP_OFS_CMD);

	always_comb
	begin
		logic [31:0] wd;
		logic [1:0] ws;
		logic [2:0] sc;
		fsp_op_t op;
		logic blocked;
		logic [3:0] msk;
		wd = avs_writedata_i & wmask;
		ws = wd[FSP_CMD_WSEL_LSB +: 2];
		sc = wd[FSP_CMD_SECT_LSB +: 3];
		op = fsp_op_t'(wd[3:0]);
		blocked = 1'b0;
		msk = 4'h0;
		hw_fire = 1'b0;
		attempt = 1'b0;
		match_fire = 1'b0;
		rd_ok = 1'b0;
		d = q;
		// Pin bank, high bit first: output, chip and write enables, reset, supply, protect.
		d.sy1 = {oe_n_i, ce_n_i, we_n_i, hw_reset_n_i, program_supply_pin_i,
			write_protect_n_i};
		d.sy2 = q.sy1;
		d.sy3 = q.sy2;
		d.pin_f = (q.sy2 & q.sy3) | (q.pin_f & (q.sy2 ^ q.sy3));
		d.we_prev = q.pin_f[3];
		d.go = 1'b0;
		d.wreq = 1'b1;
		if (q.gap != 8'h00)
			d.gap = q.gap - 8'h01;
		if (q.boot_cnt != FSP_BOOT_SETTLE)
		begin
			d.boot_cnt = q.boot_cnt + 3'h1;
			if (q.boot_cnt == FSP_BOOT_SETTLE - 3'h1)
				d.inhibit = ~q.pin_f[3] & ~q.pin_f[4] & ~q.pin_f[2] & q.pin_f[5];
		end
		else if (q.inhibit && q.pin_f[3] && !q.we_prev)
			d.inhibit = 1'b0;
		if (q.st == FSP_ST_WAIT)
		begin
			if (q.cnt == 8'h00)
			begin
				if (q.pend_clear)
					d.freeze = 1'b1;
				d.pend_clear = 1'b0;
				d.result = q.pend_result;
				d.st = FSP_ST_IDLE;
			end
			else
				d.cnt = q.cnt - 8'h01;
		end
		if (bus_go)
		begin
			d.wreq = 1'b0;
			d.rdata = 32'h0;
			if (avs_read_i)
			begin
				case (avs_address_i)
					FSP_OFS_CTRL: d.rdata = {16'h0, q.cfg, 6'h0, q.fuse, q.entry};
					FSP_OFS_CMD: d.rdata = {20'h0, q.cmd_last};
					FSP_OFS_DATA: d.rdata = {16'h0, q.data};
					FSP_OFS_STAT: d.rdata = {16'h0, prot_w, q.entry, ~q.pin_f[2],
						q.inhibit, q.freeze, q.result, q.st == FSP_ST_WAIT};
					default: d.rdata = 32'h0;
				endcase
			end
		end
		if (wr_go)
		begin
			if (avs_address_i == FSP_OFS_CTRL)
			begin
				if (avs_byteenable_i[0])
				begin
					d.entry = wd[FSP_CTRL_ENTRY];
					d.fuse = q.fuse | wd[FSP_CTRL_FUSE];
				end
				if (avs_byteenable_i[1])
					d.cfg = wd[FSP_CTRL_CFG_LSB +: 8];
			end
			else if (avs_address_i == FSP_OFS_DATA)
				d.data = (q.data & ~wmask[15:0]) | wd[15:0];
			else if (avs_address_i == FSP_OFS_CMD)
			begin
				d.cmd_last = wd[11:0];
				d.result = FSP_RES_REFUSED;
				if (q.st == FSP_ST_IDLE && !q.inhibit && q.pin_f[2])
				begin
					d.result = FSP_RES_OK;
					if (op != FSP_OP_SEC_READ)
						d.verify = 1'b0;
					case (op)
						FSP_OP_SEC_PROG:
						begin
							if (!q.entry || q.fuse)
								d.result = FSP_RES_REFUSED;
							else
							begin
								d.secret[ws] = q.secret[ws] & q.data;
								d.verify = 1'b1;
								d.st = FSP_ST_WAIT;
								d.cnt = FSP_POLL_CYC;
								d.pend_result = FSP_RES_OK;
								if ((q.data & ~q.secret[ws]) != 16'h0)
								begin
									d.cnt = FSP_TIMEOUT_CYC;
									d.pend_result = FSP_RES_TIMEOUT;
								end
								d.result = FSP_RES_NONE;
							end
						end
						FSP_OP_SEC_READ:
						begin
							if (q.entry && !q.fuse && q.verify)
							begin
								rd_ok = 1'b1;
								d.data = q.secret[ws];
							end
							else
								d.result = FSP_RES_REFUSED;
						end
						FSP_OP_UNLOCK:
						begin
							// no software unlock outside password mode
							if (!q.entry || !q.fuse || q.gap != 8'h00)
							begin
								d.result = FSP_RES_REFUSED;
								d.stage_mask = 4'h0;
							end
							else
							begin
								d.stage[ws] = q.data;
								msk = q.stage_mask | (4'h1 << ws);
								d.stage_mask = msk;
								if (msk == 4'hf)
								begin
									attempt = 1'b1;
									d.stage_mask = 4'h0;
									d.gap = FSP_UNLOCK_GAP_CYC;
									d.result = FSP_RES_MISMATCH;
									if (d.stage == q.secret)
									begin
										match_fire = 1'b1;
										d.pend_clear = 1'b1;
										d.pend_result = FSP_RES_OK;
										d.st = FSP_ST_WAIT;
										d.cnt = FSP_UNLOCK_TIME_CYC;
										d.result = FSP_RES_NONE;
									end
								end
							end
						end
						FSP_OP_FREEZE_SET: d.freeze = 1'b0;
						FSP_OP_PLOCK_PROG, FSP_OP_PLOCK_ERASE:
						begin
							d.st = FSP_ST_WAIT;
							d.result = FSP_RES_NONE;
							if (!q.freeze)
							begin
								d.cnt = FSP_TIMEOUT_CYC;
								d.pend_result = FSP_RES_TIMEOUT;
							end
							else
							begin
								d.cnt = FSP_POLL_CYC;
								d.pend_result = FSP_RES_OK;
								if (op == FSP_OP_PLOCK_PROG)
									d.plock[sc] = 1'b0;
								else
									d.plock = 8'hff;
							end
						end
						FSP_OP_VLOCK_SET: d.vlock[sc] = 1'b0;
						FSP_OP_VLOCK_CLR: d.vlock[sc] = 1'b1;
						FSP_OP_ARR_PROG, FSP_OP_ARR_ERASE:
						begin
							if (wd[FSP_CMD_SECSI])
								blocked = ~q.pin_f[0] | ~q.pin_f[1] | q.entry;
							else
								blocked = prot_w[sc] | (q.entry & (sc <= FSP_BANK0_LAST));
							d.st = FSP_ST_WAIT;
							d.cnt = FSP_POLL_CYC;
							d.result = FSP_RES_NONE;
							d.pend_result = blocked ? FSP_RES_PROTECTED : FSP_RES_OK;
							d.go = ~blocked;
							d.go_erase = (op == FSP_OP_ARR_ERASE);
							d.go_sect = sc;
						end
						FSP_OP_VLOCK_STAT: d.data = {15'h0, q.vlock[sc]};
						FSP_OP_PLOCK_STAT: d.data = {15'h0, q.plock[sc]};
						FSP_OP_FREEZE_STAT: d.data = {15'h0, q.freeze};
						default: d.result = FSP_RES_REFUSED;
					endcase
				end
			end
		end
		d.out_en = q.pin_f[2];
		if (!q.pin_f[2])
		begin
			if (q.rp_cnt != FSP_RESET_PULSE_CYC)
				d.rp_cnt = q.rp_cnt + 4'h1;
			if (q.rp_cnt == FSP_RESET_PULSE_CYC - 4'h1)
			begin
				hw_fire = 1'b1;
				d.st = FSP_ST_IDLE;
				d.cnt = 8'h00;
				d.pend_clear = 1'b0;
				d.go = 1'b0;
				d.cfg = 8'h00;
				d.entry = 1'b0;
				d.verify = 1'b0;
				d.stage_mask = 4'h0;
				d.result = FSP_RES_NONE;
				d.vlock = 8'h00;
				d.freeze = ~q.fuse;
			end
		end
		else
			d.rp_cnt = 4'h0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= FSP_RESET_Q;
		else
			q <= d;
	end

	assign avs_readdata_o = q.rdata;
	assign avs_waitrequest_o = q.wreq;
	assign out_en_o = q.out_en;
	assign bank0_block_o = q.entry;
	assign array_go_o = q.go;
	assign array_erase_o = q.go_erase;
	assign array_sector_o = q.go_sect;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_freeze_pw_release: assert property ($rose(q.freeze) && q.fuse |->
		$past(q.st == FSP_ST_WAIT && q.pend_clear && q.cnt == 8'h00))
		else $error("freeze bit released without a matching secret");
	a_freeze_sw_clear: assert property ($rose(q.freeze) && !q.fuse |-> $past(hw_fire))
		else $error("freeze bit released by software outside password mode");
	a_reset_freeze_pw: assert property (hw_fire && q.fuse |=> !q.freeze)
		else $error("freeze bit not locked after reset in password mode");
	a_secret_only_clears: assert property (((~$past(q.secret)) & q.secret) == 64'h0)
		else $error("secret bit went from 0 to 1");
	a_fuse_sticky: assert property (!$fell(q.fuse))
		else $error("secret-mode fuse was erased");
	a_unlock_spacing: assert property (attempt |-> q.gap == 8'h00 ##1
		q.gap == FSP_UNLOCK_GAP_CYC)
		else $error("unlock attempt spacing not enforced");
	// A reset pulse may legally abort the wait, so it ends the obligation too.
	a_unlock_time: assert property (match_fire && q.pin_f[2] && !q.freeze |=>
		(!q.freeze) [*8] ##[1:120] (q.freeze || !q.pin_f[2]))
		else $error("unlock did not complete in about 1 us");
	a_readback_gate: assert property (cmd_wr && avs_writedata_i[3:0] == FSP_OP_SEC_READ
		&& !(q.verify && q.entry && !q.fuse) |=> $stable(q.data))
		else $error("secret read outside programming");
	a_supply_gate: assert property (q.go |-> $past(q.pin_f[1]))
		else $error("array operation granted with supply pin low");
	a_wp_top_gate: assert property (q.go && q.go_sect >= FSP_TOP_SECT |->
		$past(q.pin_f[0]))
		else $error("top sector granted with write-protect low");
	a_vlock_reset: assert property (hw_fire |=> q.vlock == 8'h00)
		else $error("volatile locks not protected after reset");
	a_inhibit_ignore: assert property (cmd_wr && q.inhibit && q.pin_f[2] |=>
		q.result == FSP_RES_REFUSED)
		else $error("command accepted during power-up inhibit");
	a_reset_outputs: assert property (!q.pin_f[2] |=> !q.out_en)
		else $error("outputs enabled during reset pulse");
endmodule // fsp_protect
`default_nettype wire

/* verification/fsp_host.sv */
// Purpose: Host model that issues register and command cycles to the block.
// Assumes: One Avalon-MM request at a time, held until waitrequest is seen low.
// Notes: The bench calls these tasks; a stalled wait is counted in bus_err.
`timescale 1ns/1ps
`default_nettype none
module fsp_host
	import fsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i,
	output logic [4:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o
);
	int bus_err = 0;
	initial
	begin
		avs_address_o = 5'h00;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0;
	end
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_o <= a;
		avs_read_o <= ~wr;
		avs_write_o <= wr;
		avs_writedata_o <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_i !== 1'b0 && n < 64);
		if (n >= 64)
			bus_err++;
		q = avs_readdata_i;
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	// The data word goes first, because the command consumes it when taken.
	task automatic cmd(input logic [3:0] op, input logic [1:0] ws, input logic [2:0] s,
		input logic [15:0] d);
		wr(FSP_OFS_DATA, {16'h0000, d});
		wr(FSP_OFS_CMD, {21'h0, s, 2'b00, ws, op});
	endtask
	task automatic unlock(input logic [63:0] key);
		for (int i = 0; i < 4; i++)
			cmd(FSP_OP_UNLOCK, 2'(i), 3'h0, key[16 * i +: 16]);
	endtask
endmodule // fsp_host
`default_nettype wire

/* verification/fsp_protect_tb.sv */
// Purpose: Self-checking bench of the sector write-protection block.
// Assumes: 100 MHz clock; the host model drives the register port.
// Notes: Pins change only between commands and are given time to sync.
`timescale 1ns/1ps
`default_nettype none
module fsp_protect_tb
	import fsp_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wp_n = 1'b1;
	logic vpp = 1'b1;
	logic hrst_n = 1'b1;
	logic we_n = 1'b1;
	logic ce_n = 1'b1;
	logic oe_n = 1'b1;
	logic [4:0] addr;
	logic rd_s;
	logic wr_s;
	logic wait_s;
	logic out_en;
	logic bank0;
	logic go;
	logic erase;
	logic go_erase;
	logic [2:0] sect;
	logic [2:0] go_sect;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] q;
	logic [63:0] key = 64'hdef0_9abc_5678_1234;
	int clr[3] = '{2, 3, 7};
	int err_count = 0;
	int check_count = 0;
	int go_count = 0;
	always #5 clk_i = ~clk_i;
	fsp_host u_host (.clk_i(clk_i), .avs_readdata_i(rdata), .avs_waitrequest_i(wait_s),
		.avs_address_o(addr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdata));
	fsp_protect dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_s),
		.avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .write_protect_n_i(wp_n),
		.program_supply_pin_i(vpp), .hw_reset_n_i(hrst_n), .we_n_i(we_n), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .out_en_o(out_en), .bank0_block_o(bank0), .array_go_o(go),
		.array_erase_o(erase), .array_sector_o(sect));
	always @(posedge clk_i)
		if (go === 1'b1)
		begin
			go_count++;
			go_sect = sect;
			go_erase = erase;
		end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic res(input fsp_res_t e);
		int n;
		n = 0;
		do
		begin
			u_host.rd(FSP_OFS_STAT, q);
			n++;
		end
		while (q[0] !== 1'b0 && n < 100);
		chk({29'h0, q[3:1]}, {29'h0, e});
	endtask
	task automatic data(input logic [31:0] e);
		u_host.rd(FSP_OFS_DATA, q);
		chk(q, e);
	endtask
	task automatic sbit(input int b, input logic e);
		u_host.rd(FSP_OFS_STAT, q);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask
	task automatic arr(input fsp_op_t op, input logic [2:0] s, input logic ok);
		int n;
		n = go_count;
		u_host.cmd(op, 2'h0, s, 16'h0);
		if (!ok)
			sbit(0, 1'b1);
		res(ok ? FSP_RES_OK : FSP_RES_PROTECTED);
		chk(go_count - n, {31'h0, ok});
		if (ok)
			chk({28'h0, go_erase, go_sect}, {28'h0, op == FSP_OP_ARR_ERASE, s});
	endtask
	task automatic hw_pulse;
		@(posedge clk_i);
		hrst_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		u_host.cmd(FSP_OP_VLOCK_CLR, 2'h0, 3'h5, 16'h0);
		chk({31'h0, out_en}, 32'h0);
		@(posedge clk_i);
		hrst_n <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic close_out;
		err_count += u_host.bus_err;
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		u_host.rd(FSP_OFS_STAT, q);
		chk(q, 32'h0000ff10);
		u_host.wr(FSP_OFS_CTRL, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, bank0}, 32'h1);
		u_host.cmd(FSP_OP_SEC_PROG, 2'h0, 3'h0, 16'hffff);
		res(FSP_RES_OK);
		u_host.cmd(FSP_OP_SEC_READ, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_OK);
		data(32'hffff);
		for (int i = 0; i < 4; i++)
		begin
			u_host.cmd(FSP_OP_SEC_PROG, 2'(i), 3'h0, key[16 * i +: 16]);
			res(FSP_RES_OK);
			u_host.cmd(FSP_OP_SEC_READ, 2'(i), 3'h0, 16'h0);
			res(FSP_RES_OK);
			data({16'h0, key[16 * i +: 16]});
		end
		u_host.cmd(FSP_OP_SEC_PROG, 2'h0, 3'h0, 16'hffff);
		res(FSP_RES_TIMEOUT);
		u_host.cmd(FSP_OP_FREEZE_STAT, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_OK);
		data(32'h1);
		u_host.cmd(FSP_OP_SEC_READ, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_REFUSED);
		$display("done: secret store");
		u_host.wr(FSP_OFS_CTRL, 32'h3);
		u_host.cmd(FSP_OP_SEC_PROG, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_REFUSED);
		u_host.wr(FSP_OFS_CTRL, 32'h1);
		u_host.rd(FSP_OFS_CTRL, q);
		chk(q, 32'h3);
		u_host.cmd(FSP_OP_FREEZE_SET, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_OK);
		sbit(4, 1'b0);
		u_host.cmd(FSP_OP_PLOCK_PROG, 2'h0, 3'h2, 16'h0);
		res(FSP_RES_TIMEOUT);
		u_host.unlock(key ^ 64'h1);
		res(FSP_RES_MISMATCH);
		u_host.unlock(key);
		res(FSP_RES_REFUSED);
		repeat (120) @(posedge clk_i);
		u_host.unlock(key);
		repeat (50) @(posedge clk_i);
		sbit(0, 1'b1);
		res(FSP_RES_OK);
		sbit(4, 1'b1);
		$display("done: unlock");
		u_host.cmd(FSP_OP_PLOCK_PROG, 2'h0, 3'h2, 16'h0);
		res(FSP_RES_OK);
		foreach (clr[i])
		begin
			u_host.cmd(FSP_OP_VLOCK_CLR, 2'h0, 3'(clr[i]), 16'h0);
			res(FSP_RES_OK);
		end
		u_host.rd(FSP_OFS_STAT, q);
		chk({24'h0, q[15:8]}, 32'h77);
		u_host.cmd(FSP_OP_VLOCK_STAT, 2'h0, 3'h3, 16'h0);
		res(FSP_RES_OK);
		data(32'h1);
		u_host.cmd(FSP_OP_PLOCK_STAT, 2'h0, 3'h2, 16'h0);
		res(FSP_RES_OK);
		data(32'h0);
		arr(FSP_OP_ARR_PROG, 3'h3, 1'b1);
		arr(FSP_OP_ARR_ERASE, 3'h3, 1'b1);
		arr(FSP_OP_ARR_PROG, 3'h2, 1'b0);
		arr(FSP_OP_ARR_PROG, 3'h4, 1'b0);
		@(posedge clk_i);
		vpp <= 1'b0;
		repeat (8) @(posedge clk_i);
		arr(FSP_OP_ARR_PROG, 3'h3, 1'b0);
		@(posedge clk_i);
		vpp <= 1'b1;
		wp_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		u_host.rd(FSP_OFS_STAT, q);
		chk({24'h0, q[15:8]}, 32'hf7);
		arr(FSP_OP_ARR_PROG, 3'h7, 1'b0);
		@(posedge clk_i);
		wp_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		arr(FSP_OP_ARR_PROG, 3'h7, 1'b1);
		u_host.cmd(FSP_OP_VLOCK_CLR, 2'h0, 3'h1, 16'h0);
		res(FSP_RES_OK);
		arr(FSP_OP_ARR_PROG, 3'h1, 1'b0);
		u_host.wr(FSP_OFS_CTRL, 32'hab01);
		hw_pulse();
		chk({31'h0, out_en}, 32'h1);
		u_host.rd(FSP_OFS_CTRL, q);
		chk(q, 32'h2);
		u_host.rd(FSP_OFS_STAT, q);
		chk(q, 32'h0000ff04);
		u_host.cmd(FSP_OP_VLOCK_CLR, 2'h0, 3'h5, 16'h0);
		res(FSP_RES_OK);
		u_host.wr(FSP_OFS_CMD, 32'h809);
		res(FSP_RES_OK);
		@(posedge clk_i);
		wp_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		u_host.wr(FSP_OFS_CMD, 32'h809);
		res(FSP_RES_PROTECTED);
		@(posedge clk_i);
		wp_n <= 1'b1;
		$display("done: pins and reset");
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		we_n <= 1'b0;
		ce_n <= 1'b0;
		hrst_n <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		sbit(5, 1'b1);
		@(posedge clk_i);
		hrst_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		u_host.cmd(FSP_OP_FREEZE_SET, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_REFUSED);
		@(posedge clk_i);
		we_n <= 1'b1;
		ce_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		sbit(5, 1'b0);
		u_host.wr(FSP_OFS_CTRL, 32'h1);
		u_host.cmd(FSP_OP_FREEZE_SET, 2'h0, 3'h0, 16'h0);
		res(FSP_RES_OK);
		u_host.unlock(key);
		res(FSP_RES_REFUSED);
		sbit(4, 1'b0);
		hw_pulse();
		sbit(4, 1'b1);
		$display("done: power up");
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		close_out();
	end
endmodule // fsp_protect_tb
`default_nettype wire
